// file: pkg/fpe_regs.vh
// constants for the flash program/erase host controller
`ifndef FPE_REGS_VH
`define FPE_REGS_VH
// command cycle addresses and data
`define FPE_ADDR_555 20'h00555
`define FPE_ADDR_2AA 20'h002AA
`define FPE_DAT_AA 8'hAA
`define FPE_DAT_55 8'h55
`define FPE_DAT_PROG 8'hA0
`define FPE_DAT_ERS 8'h80
`define FPE_DAT_CHIP 8'h10
`define FPE_DAT_SECT 8'h30
`define FPE_DAT_SUSP 8'hB0
`define FPE_DAT_RESUME 8'h30
// operation codes on op_sel
`define FPE_OP_PROG 3'h0
`define FPE_OP_CHIP 3'h1
`define FPE_OP_SECT 3'h2
`define FPE_OP_SUSP 3'h3
`define FPE_OP_RESUME 3'h4
`define FPE_OP_READ 3'h5
// data bit positions
`define FPE_DATA_POLL_BIT 7
`define FPE_TOGGLE_STATUS_BIT 6
// sector field of the address
`define FPE_SECT_LSB 13
// bus phase length in clocks minus one (100 ns each, above every strobe minimum)
`define FPE_PHASE_CYC 2'h1
// resume settle delay: 10 ms at 100 ns
`define FPE_RESUME_DELAY_MS 10
`define FPE_RESUME_DELAY_CYC ((`FPE_RESUME_DELAY_MS * 1000000) / 100)
`define FPE_SUSP_LOOP_LIMIT 11'h400
`endif

// file: core/fpe_bus_cycle.v
// single asynchronous bus cycle (write or read) on the flash pins
`include "fpe_regs.vh"
module fpe_bus_cycle (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // request
    input wire start,
    input wire is_write,
    input wire use_ce_ctrl,
    input wire [19:0] addr,
    input wire [7:0] wdata,
    output reg done,
    output reg [7:0] rdata,
    // flash pins
    output reg [19:0] f_addr,
    output reg [7:0] f_dq_o,
    output reg f_dq_oe,
    input wire [7:0] f_dq_i,
    output reg f_ce_n,
    output reg f_oe_n,
    output reg f_we_n
);
    localparam S_IDLE = 4'b0001;
    localparam S_SET = 4'b0010;
    localparam S_ACT = 4'b0100;
    localparam S_END = 4'b1000;
    reg [3:0] st_r;
    reg wr_r;
    reg cec_r;
    reg [1:0] cnt_r;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            wr_r <= 1'b0;
            cec_r <= 1'b0;
            cnt_r <= 2'h0;
            done <= 1'b0;
            rdata <= 8'h00;
            f_addr <= 20'h00000;
            f_dq_o <= 8'h00;
            f_dq_oe <= 1'b0;
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
        end else begin
            done <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (start) begin
                        wr_r <= is_write;
                        cec_r <= use_ce_ctrl;
                        f_addr <= addr;
                        f_dq_o <= wdata;
                        f_dq_oe <= is_write;
                        // ce-controlled write: we goes low first, ce last
                        if (is_write && use_ce_ctrl)
                            f_we_n <= 1'b0;
                        if (is_write && !use_ce_ctrl)
                            f_ce_n <= 1'b0;
                        cnt_r <= `FPE_PHASE_CYC;
                        st_r <= S_SET;
                    end
                end
                S_SET: begin
                    // every read is its own ce/oe pulse
                    if (!wr_r) begin
                        f_ce_n <= 1'b0;
                        f_oe_n <= 1'b0;
                    end else if (cec_r) begin
                        f_ce_n <= 1'b0;
                    end else begin
                        f_we_n <= 1'b0;
                    end
                    st_r <= S_ACT;
                end
                S_ACT: begin
                    if (cnt_r != 2'h0) begin
                        cnt_r <= cnt_r - 2'h1;
                    end else begin
                        rdata <= f_dq_i;
                        if (!wr_r) begin
                            f_oe_n <= 1'b1;
                            f_ce_n <= 1'b1;
                        end else if (cec_r) begin
                            f_ce_n <= 1'b1; // ce releases first
                        end else begin
                            f_we_n <= 1'b1;
                        end
                        st_r <= S_END;
                    end
                end
                S_END: begin
                    f_ce_n <= 1'b1;
                    f_we_n <= 1'b1;
                    f_dq_oe <= 1'b0;
                    done <= 1'b1;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule

// file: core/fpe_host.v
// host controller for flash embedded program, erase and suspend/resume
// Notes on behaviour
// - host checks completion only after algorithm start, by polling bits
// - B0h during sector erase suspends it
// - after suspend host polls toggle bit until it stops
// - 30h while suspended resumes the erase
// - after many suspend/resume loops host waits 10 ms after resume
// - each status read is a separate ce/oe access
`include "fpe_regs.vh"
module fpe_host #(
    parameter RESUME_DELAY_CYC = `FPE_RESUME_DELAY_CYC
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // user command port
    input wire cmd_valid,
    input wire [2:0] op_sel,
    input wire use_ce_ctrl,
    input wire [19:0] program_target_address,
    input wire [7:0] program_target_byte,
    output reg cmd_ready,
    output reg op_done,
    output reg op_fail,
    output reg [7:0] read_data,
    output reg busy_seen,
    // flash pins
    output reg [19:0] f_addr,
    output reg [7:0] f_dq_o,
    output reg f_dq_oe,
    input wire [7:0] f_dq_i,
    output reg f_ce_n,
    output reg f_oe_n,
    output reg f_we_n,
    input wire ready_busy_output
);
    ////////////////////////////////////////////////////////////////////////
    localparam S_IDLE = 6'b000001;
    localparam S_CMD = 6'b000010;
    localparam S_POLL1 = 6'b000100;
    localparam S_POLL2 = 6'b001000;
    localparam S_WAIT = 6'b010000;
    localparam S_DONE = 6'b100000;
    reg rs1_r;
    reg rs2_r;
    wire rst_n;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    assign rst_n = rs2_r;
    ////////////////////////////////////////////////////////////////////////
    reg [5:0] st_r;
    reg [2:0] op_r;
    reg cec_r;
    reg [19:0] adr_r;
    reg [7:0] dat_r;
    reg [2:0] idx_r;
    reg [2:0] ncyc_r;
    reg [7:0] prev_r;
    reg [10:0] loops_r;
    reg [23:0] dly_r;
    reg bc_start_r;
    reg bc_wr_r;
    reg [19:0] bc_addr_r;
    reg [7:0] bc_wdata_r;
    wire bc_done;
    wire [7:0] bc_rdata;
    wire [19:0] p_addr;
    wire [7:0] p_dq_o;
    wire p_dq_oe;
    wire p_ce_n;
    wire p_oe_n;
    wire p_we_n;
    fpe_bus_cycle u_bus (
        .clk(clk),
        .rst_n(rst_n),
        .start(bc_start_r),
        .is_write(bc_wr_r),
        .use_ce_ctrl(cec_r),
        .addr(bc_addr_r),
        .wdata(bc_wdata_r),
        .done(bc_done),
        .rdata(bc_rdata),
        .f_addr(p_addr),
        .f_dq_o(p_dq_o),
        .f_dq_oe(p_dq_oe),
        .f_dq_i(f_dq_i),
        .f_ce_n(p_ce_n),
        .f_oe_n(p_oe_n),
        .f_we_n(p_we_n)
    );
    // register pins once more so every top output comes from a flop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            f_addr <= 20'h00000;
            f_dq_o <= 8'h00;
            f_dq_oe <= 1'b0;
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
        end else begin
            f_addr <= p_addr;
            f_dq_o <= p_dq_o;
            f_dq_oe <= p_dq_oe;
            f_ce_n <= p_ce_n;
            f_oe_n <= p_oe_n;
            f_we_n <= p_we_n;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // command sequence table: address and data of cycle idx for the op
    reg [19:0] seq_a;
    reg [7:0] seq_d;
    always @* begin
        seq_a = `FPE_ADDR_555;
        seq_d = `FPE_DAT_AA;
        if (idx_r == 3'h1 || idx_r == 3'h4) begin
            seq_a = `FPE_ADDR_2AA;
            seq_d = `FPE_DAT_55;
        end else if (idx_r == 3'h3) begin
            seq_d = `FPE_DAT_AA;
        end
        case (op_r)
            `FPE_OP_PROG: begin
                if (idx_r == 3'h2)
                    seq_d = `FPE_DAT_PROG; // A0h to 555h
                if (idx_r == 3'h3) begin
                    seq_a = adr_r; // target byte last; no verify follows
                    seq_d = dat_r;
                end
            end
            `FPE_OP_CHIP, `FPE_OP_SECT: begin
                if (idx_r == 3'h2)
                    seq_d = `FPE_DAT_ERS;
                if (idx_r == 3'h5) begin
                    // chip erase, or sector chosen by high address bits
                    seq_a = (op_r == `FPE_OP_SECT) ?
                        {adr_r[19:`FPE_SECT_LSB], 13'h0000} : `FPE_ADDR_555;
                    seq_d = (op_r == `FPE_OP_SECT) ? `FPE_DAT_SECT : `FPE_DAT_CHIP;
                end
            end
            `FPE_OP_SUSP: begin
                seq_a = adr_r;
                seq_d = `FPE_DAT_SUSP;
            end
            `FPE_OP_RESUME: begin
                seq_a = adr_r;
                seq_d = `FPE_DAT_RESUME;
            end
            default: begin
                seq_a = adr_r;
                seq_d = 8'h00;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    wire tog_moved;
    assign tog_moved = bc_rdata[`FPE_TOGGLE_STATUS_BIT] != prev_r[`FPE_TOGGLE_STATUS_BIT];
    // expected final top bit: written bit for program, 1 for erase
    wire poll_ok;
    assign poll_ok = (op_r == `FPE_OP_PROG) ?
        (bc_rdata[`FPE_DATA_POLL_BIT] == dat_r[`FPE_DATA_POLL_BIT]) :
        bc_rdata[`FPE_DATA_POLL_BIT];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            op_r <= `FPE_OP_READ;
            cec_r <= 1'b0;
            adr_r <= 20'h00000;
            dat_r <= 8'h00;
            idx_r <= 3'h0;
            ncyc_r <= 3'h0;
            prev_r <= 8'h00;
            loops_r <= 11'h000;
            dly_r <= 24'h000000;
            bc_start_r <= 1'b0;
            bc_wr_r <= 1'b0;
            bc_addr_r <= 20'h00000;
            bc_wdata_r <= 8'h00;
            cmd_ready <= 1'b0;
            op_done <= 1'b0;
            op_fail <= 1'b0;
            read_data <= 8'h00;
            busy_seen <= 1'b0;
        end else begin
            bc_start_r <= 1'b0;
            op_done <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    cmd_ready <= 1'b1;
                    // a request held across op_done must wait for cmd_ready
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op_fail <= 1'b0;
                        busy_seen <= 1'b0;
                        op_r <= op_sel;
                        cec_r <= use_ce_ctrl;
                        adr_r <= program_target_address;
                        dat_r <= program_target_byte;
                        idx_r <= 3'h0;
                        case (op_sel)
                            `FPE_OP_PROG: ncyc_r <= 3'h4;
                            `FPE_OP_CHIP, `FPE_OP_SECT: ncyc_r <= 3'h6;
                            `FPE_OP_SUSP, `FPE_OP_RESUME: ncyc_r <= 3'h1;
                            default: ncyc_r <= 3'h0;
                        endcase
                        st_r <= S_CMD;
                    end
                end
                S_CMD: begin
                    // issue next cycle; ncyc 0 means a plain array read
                    bc_start_r <= 1'b1;
                    bc_wr_r <= (ncyc_r != 3'h0);
                    bc_addr_r <= seq_a;
                    bc_wdata_r <= seq_d;
                    st_r <= S_WAIT;
                end
                S_WAIT: begin
                    if (bc_done) begin
                        if (ncyc_r == 3'h0) begin
                            read_data <= bc_rdata;
                            st_r <= S_DONE;
                        end else if (idx_r + 3'h1 != ncyc_r) begin
                            idx_r <= idx_r + 3'h1;
                            st_r <= S_CMD;
                        end else if (op_r == `FPE_OP_RESUME) begin
                            // long suspend/resume loops get a settle delay
                            if (loops_r >= `FPE_SUSP_LOOP_LIMIT)
                                dly_r <= RESUME_DELAY_CYC[23:0];
                            else
                                loops_r <= loops_r + 11'h001;
                            st_r <= S_POLL2;
                        end else begin
                            // polling starts only after the final command write
                            bc_start_r <= 1'b1;
                            bc_wr_r <= 1'b0;
                            bc_addr_r <= adr_r;
                            st_r <= S_POLL1;
                        end
                    end
                end
                S_POLL1: begin
                    if (bc_done) begin
                        prev_r <= bc_rdata;
                        // a fresh ce/oe read each time
                        bc_start_r <= 1'b1;
                        st_r <= S_POLL2;
                    end
                end
                S_POLL2: begin
                    if (op_r == `FPE_OP_RESUME) begin
                        if (dly_r != 24'h000000)
                            dly_r <= dly_r - 24'h000001;
                        else
                            st_r <= S_DONE;
                    end else if (bc_done) begin
                        if (!ready_busy_output)
                            busy_seen <= 1'b1;
                        read_data <= bc_rdata; // status while busy
                        if (!tog_moved) begin
                            // toggle stopped: done, or suspend settled
                            if (op_r != `FPE_OP_SUSP && !poll_ok)
                                op_fail <= 1'b1;
                            st_r <= S_DONE;
                        end else begin
                            prev_r <= bc_rdata;
                            bc_start_r <= 1'b1;
                        end
                    end
                end
                S_DONE: begin
                    if (op_r == `FPE_OP_CHIP || op_r == `FPE_OP_SECT)
                        loops_r <= 11'h000;
                    op_done <= 1'b1;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule

// file: bench/fpe_flash_model.sv
// behavioural flash device answering the host controller
module fpe_flash_model #(
    parameter int PROG_CYC = 90,
    parameter int ERASE_CYC = 400
) (
    // bus pins
    input wire logic [19:0] f_addr,
    input wire logic [7:0] f_dq,
    input wire logic f_ce_n,
    input wire logic f_oe_n,
    input wire logic f_we_n,
    // device outputs
    output logic [7:0] dq_drv,
    output logic ready_busy_output
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [int];
    logic [7:0] last = 8'hFF;
    logic [7:0] pbyte = 8'h00;
    logic [6:0] sect = 7'h00;
    logic busy = 0, ers = 0, susp = 0, tog = 0, sec_mode = 0;
    int step = 0;
    int remain = 0;
    wire wr_n = f_we_n | f_ce_n;
    wire rd_n = f_ce_n | f_oe_n;
    wire a555 = f_addr == 20'h00555;
    function automatic logic [7:0] rd(input logic [19:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
    endfunction
    task automatic start(input int n, input logic e, input logic s);
        remain = n;
        ers = e;
        sec_mode = s;
        busy = 1;
    endtask
    ////////////////////////////////////////
    // a write lands when the earlier of we and ce rises
    always @(posedge wr_n) begin
        if (busy) begin
            if (ers && sec_mode && f_dq == 8'hB0)
                susp = 1;
            else if (susp && f_dq == 8'h30)
                susp = 0;
        end else if (step == 6) begin
            mem[int'(f_addr)] = rd(f_addr) & f_dq;
            pbyte = f_dq;
            start(PROG_CYC, 0, 0);
        end else if (step == 5 && a555 && f_dq == 8'h10) begin
            start(ERASE_CYC, 1, 0);
        end else if (step == 5 && f_dq == 8'h30) begin
            sect = f_addr[19:13];
            start(ERASE_CYC, 1, 1);
        end
        if (busy) step = 0;
        else if (step == 2 && a555 && f_dq == 8'hA0) step = 6;
        else if (a555 && f_dq == 8'hAA && (step == 0 || step == 3) ||
                 f_addr == 20'h002AA && f_dq == 8'h55 && (step == 1 || step == 4) ||
                 step == 2 && a555 && f_dq == 8'h80) step = step + 1;
        else step = 0;
    end
    // erase time scaled down; suspend freezes the countdown
    always #100 begin
        if (busy && !susp && remain > 1) remain--;
        else if (busy && !susp) begin
            if (ers && !sec_mode) mem.delete();
            if (ers && sec_mode) foreach (mem[k]) if (k[19:13] == sect) mem[k] = 8'hFF;
            busy = 0;
        end
    end
    always @(negedge rd_n) begin
        if (busy && !susp) last = {ers ? 1'b0 : ~pbyte[7], tog, 6'h00};
        else last = rd(f_addr);
    end
    always @(posedge rd_n) if (busy && !susp) tog = ~tog;
    // released bus shows the inverse so a stale value cannot pass
    assign dq_drv = rd_n ? ~last : last;
    assign ready_busy_output = !(busy && !susp);
endmodule

// file: bench/fpe_host_properties.sv
// assertions on the flash host controller ports
module fpe_host_properties (
    // clock and reset
    input wire clk,
    input wire nrst,
    // user side
    input wire cmd_valid,
    input wire cmd_ready,
    input wire op_done,
    input wire op_fail,
    // flash pins
    input wire [19:0] f_addr,
    input wire [7:0] f_dq_o,
    input wire f_dq_oe,
    input wire f_ce_n,
    input wire f_oe_n,
    input wire f_we_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    property p_dq_in_write;
        !f_we_n && !f_ce_n |-> f_dq_oe;
    endproperty
    a_dq_in_write: assert property (p_dq_in_write) else $error("data off in write");
    property p_read_clean;
        !f_oe_n |-> !f_dq_oe && f_we_n;
    endproperty
    a_read_clean: assert property (p_read_clean) else $error("drive during read");
    property p_write_stable;
        !f_we_n && !f_ce_n && !$past(f_we_n) && !$past(f_ce_n) |-> $stable(f_addr) && $stable(f_dq_o);
    endproperty
    a_write_stable: assert property (p_write_stable) else $error("write moved");
    property p_write_len;
        $fell(f_we_n | f_ce_n) |=> ##[0:5] (f_we_n | f_ce_n);
    endproperty
    a_write_len: assert property (p_write_len) else $error("write stuck");
    property p_read_sep;
        $fell(f_ce_n | f_oe_n) |-> ##[1:6] $rose(f_ce_n | f_oe_n);
    endproperty
    a_read_sep: assert property (p_read_sep) else $error("read not ended");
    property p_done_ready;
        op_done |=> cmd_ready && !op_done;
    endproperty
    a_done_ready: assert property (p_done_ready) else $error("done handshake");
    property p_idle_bus;
        cmd_ready && $past(cmd_ready) |-> f_ce_n && f_oe_n && f_we_n && !f_dq_oe;
    endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("bus active idle");
    property p_fail_clear;
        cmd_valid && cmd_ready |=> !op_fail && !cmd_ready;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("request not taken");
endmodule
bind fpe_host fpe_host_properties u_props (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .op_done(op_done), .op_fail(op_fail), .f_addr(f_addr),
    .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n));

// file: bench/testbench.sv
// self-checking bench for the flash program/erase host controller
`include "fpe_regs.vh"
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %0t %s", $time, m); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0;
    logic nrst = 0;
    logic cmd_valid = 0;
    logic ce_ctl = 0;
    logic [2:0] op = 0;
    logic [19:0] pta = 0;
    logic [7:0] ptb = 0;
    wire cmd_ready, op_done, op_fail, busy_seen, f_dq_oe, f_ce_n, f_oe_n, f_we_n, rb;
    wire [7:0] read_data, f_dq_o, dq_drv;
    wire [19:0] f_addr;
    wire [7:0] f_dq = f_dq_oe ? f_dq_o : dq_drv;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    fpe_host #(.RESUME_DELAY_CYC(20)) uut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .op_sel(op), .use_ce_ctrl(ce_ctl), .program_target_address(pta),
        .program_target_byte(ptb), .cmd_ready(cmd_ready), .op_done(op_done),
        .op_fail(op_fail), .read_data(read_data), .busy_seen(busy_seen), .f_addr(f_addr),
        .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_dq_i(f_dq), .f_ce_n(f_ce_n),
        .f_oe_n(f_oe_n), .f_we_n(f_we_n), .ready_busy_output(rb));
    fpe_flash_model dev (.f_addr(f_addr), .f_dq(f_dq), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n),
        .f_we_n(f_we_n), .dq_drv(dq_drv), .ready_busy_output(rb));
    ////////////////////////////////////////
    task automatic summarize();
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // request is held until taken; wt waits for the done pulse
    task automatic run_op(input logic [2:0] o, input logic c, input logic [19:0] a,
                          input logic [7:0] d, input logic wt);
        @(negedge clk);
        cmd_valid = 1;
        op = o;
        ce_ctl = c;
        pta = a;
        ptb = d;
        while (cmd_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        cmd_valid = 0;
        while (wt && op_done !== 1'b1) @(negedge clk);
    endtask
    task automatic t_program();
        logic [19:0] a [2] = '{20'h0C123, 20'h1A077};
        logic [7:0] d [2] = '{8'h5A, 8'hA5};
        for (int i = 0; i < 2; i++) begin
            run_op(`FPE_OP_PROG, i[0], a[i], d[i], 1);
            `CHK(op_fail, 1'b0, "program poll");
            `CHK(busy_seen, 1'b1, "program busy");
            `CHK(rb, 1'b1, "ready after program");
            run_op(`FPE_OP_READ, 0, a[i], 8'h00, 1);
            `CHK(read_data, d[i], "program readback");
        end
    endtask
    task automatic t_chip();
        run_op(`FPE_OP_CHIP, 0, 20'h00000, 8'h00, 1);
        `CHK(op_fail, 1'b0, "chip erase poll");
        `CHK(busy_seen, 1'b1, "chip erase busy");
        run_op(`FPE_OP_READ, 0, 20'h0C123, 8'h00, 1);
        `CHK(read_data, 8'hFF, "chip erase readback");
    endtask
    // host reset mid-erase is the only way to reach a running erase
    task automatic t_suspend();
        run_op(`FPE_OP_PROG, 0, 20'h06010, 8'h3C, 1);
        run_op(`FPE_OP_PROG, 1, 20'h0A020, 8'hC3, 1);
        run_op(`FPE_OP_SECT, 0, 20'h06000, 8'h00, 0);
        while (rb !== 1'b0) @(negedge clk);
        repeat (30) @(negedge clk);
        nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        `CHK(rb, 1'b0, "erase outlives host reset");
        run_op(`FPE_OP_SUSP, 0, 20'h06000, 8'h00, 1);
        `CHK(rb, 1'b1, "erase suspended");
        run_op(`FPE_OP_READ, 0, 20'h0A020, 8'h00, 1);
        `CHK(read_data, 8'hC3, "read while suspended");
        run_op(`FPE_OP_RESUME, 0, 20'h06000, 8'h00, 1);
        `CHK(rb, 1'b0, "erase resumed");
        while (rb !== 1'b1) @(negedge clk);
        run_op(`FPE_OP_READ, 0, 20'h06010, 8'h00, 1);
        `CHK(read_data, 8'hFF, "sector erased");
        run_op(`FPE_OP_READ, 0, 20'h0A020, 8'h00, 1);
        `CHK(read_data, 8'hC3, "other sector kept");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("FAIL %0t timeout", $time);
            summarize();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1;
        t_program();
        t_chip();
        t_suspend();
        summarize();
    end
endmodule
